// [ptch_map.svh]
`ifndef PTCH_MAP_SVH
`define PTCH_MAP_SVH
// APB register byte offsets
`define PTCH_OFS_CMD      12'h000
`define PTCH_OFS_LOC      12'h004
`define PTCH_OFS_ITEM     12'h008
`define PTCH_OFS_VALUE    12'h00C
`define PTCH_OFS_RESULT   12'h010
`define PTCH_OFS_IRQ_STS  12'h014
`define PTCH_OFS_IRQ_MSK  12'h018
`define PTCH_OFS_POL      12'h01C
`define PTCH_OFS_COMMON   12'h020
`define PTCH_OFS_CURSTEP  12'h024
`define PTCH_OFS_RD_STEP  12'h028
`define PTCH_OFS_RD_ITEM  12'h02C
`define PTCH_OFS_RD_DATA  12'h030
// Command codes in CMD[1:0]
`define PTCH_CMD_POL      2'h1
`define PTCH_CMD_COMMON   2'h2
`define PTCH_CMD_STEP     2'h3
// Error numbers
`define PTCH_ERR_NONE     16'h0000
`define PTCH_ERR_SLOT     16'h0003
`define PTCH_ERR_AXIS     16'h0006
`define PTCH_ERR_STEP     16'h000B
`define PTCH_ERR_ITEM     16'h000C
`define PTCH_ERR_VALUE    16'h000D
// Field limits
`define PTCH_POL_BITS     6
`define PTCH_CI_ENC_MAX   8'h01
`define PTCH_CI_ENC_MIN   8'h02
`define PTCH_CI_OVR       8'h03
`define PTCH_CI_ENC_FMT   8'h04
`define PTCH_SI_GOAL      8'h01
`define PTCH_SI_AUX       8'h02
`define PTCH_SI_SPEED     8'h03
`define PTCH_SI_CTRL      8'h08
`define PTCH_SI_PATTERN   8'h09
`define PTCH_SI_REPSTEP   8'h10
`define PTCH_SPEED_MAX    32'h001E8480
`define PTCH_U16_MAX      32'h0000FFFF
`define PTCH_MAX_STEP     8'h96
`endif

// [ptch_pkg.sv]
package ptch_pkg;
  typedef enum logic [2:0] {
    PTCH_IDLE  = 3'b001,
    PTCH_CHECK = 3'b010,
    PTCH_WRITE = 3'b100
  } ptch_state_t;
endpackage

// [ptch_handler.sv]
// Notes on behaviour
// - Request strobe starts teaching on addressed axis
// - Target module chosen by base and slot
// - Axis other than 0 or 1 gives error 6
// - Done stays 1 after first operation; error shown
// - Taught values volatile; flash save is separate
// - Polarity value read bit by bit
// - Bit 0 normally open, 1 normally closed
// - Bits 0..5 map signals; 6..15 ignored
// - Common items 1,2 select signed 32-bit encoder max and min
// - Item 3 selects override: percent or speed
// - Item 4 selects encoder input format 0..2
// - Step item 1..16 picks field; pattern 0..2
// - Step zero means the current step
// - Items 1,2 are signed goal and aux point
// - Item 3 speed between 1 and 2,000,000
// - Item 8 control: position or speed
`timescale 1ns/1ns
`default_nettype none
`include "ptch_map.svh"
module ptch_handler #(
  parameter int  STEPS = 150,
  parameter logic [7:0] MY_BASE = 8'h00,
  parameter logic [7:0] MY_SLOT = 8'h01
) (
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  current_step_x,
  input  wire logic [7:0]  current_step_y,
  output logic      [11:0] polarity_nc,
  output logic             irq
);

  localparam int NITEM = 16;
  // Step store: two axes, steps 1..STEPS, 16 fields each
  logic [31:0] step_mem [0:2*(STEPS+1)*NITEM-1];

  logic        wr_en;
  logic        rd_en;
  logic [31:0] cmd_q;
  logic [31:0] loc_q;
  logic [31:0] item_q;
  logic [31:0] value_q;
  logic        done_q;
  logic [15:0] err_q;
  logic [1:0]  sts_q;
  logic [1:0]  msk_q;
  logic [5:0]  pol_q [0:1];
  logic [31:0] enc_max_q [0:1];
  logic [31:0] enc_min_q [0:1];
  logic        ovr_q [0:1];
  logic [1:0]  enc_fmt_q [0:1];
  logic [7:0]  rd_step_q;
  logic [7:0]  rd_item_q;
  logic [31:0] rd_data_q;
  logic        start_q;
  logic [15:0] chk_err_q;
  logic [7:0]  eff_step_q;
  logic        fin_pulse;
  logic        err_pulse;
  ptch_pkg::ptch_state_t state_q;

  // Flat index into the step store
  function automatic int sidx(input logic ax, input logic [7:0] st,
                              input logic [7:0] it);
    sidx = ((int'(ax) * (STEPS + 1) + int'(st)) * NITEM) + int'(it) - 1;
  endfunction

  // Range check for a value against an unsigned upper bound
  function automatic logic in_u(input logic [31:0] v,
                                input logic [31:0] hi);
    in_u = (v <= hi);
  endfunction

  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && penable && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  // Register writes; starting a command stays blocked while busy
  always_ff @(posedge core_clk)
  begin
    start_q <= 1'b0;
    if (srst)
    begin
      cmd_q   <= 32'h00000000;
      loc_q   <= 32'h00000000;
      item_q  <= 32'h00000000;
      value_q <= 32'h00000000;
      msk_q   <= 2'h0;
      rd_step_q <= 8'h00;
      rd_item_q <= 8'h00;
    end
    else if (wr_en)
    begin
      unique case (paddr)
        `PTCH_OFS_CMD:
        begin
          cmd_q   <= pwdata;
          start_q <= pwdata[1:0] != 2'h0 && state_q == ptch_pkg::PTCH_IDLE;
        end
        `PTCH_OFS_LOC:     loc_q     <= pwdata;
        `PTCH_OFS_ITEM:    item_q    <= pwdata;
        `PTCH_OFS_VALUE:   value_q   <= pwdata;
        `PTCH_OFS_IRQ_MSK: msk_q     <= pwdata[1:0];
        `PTCH_OFS_RD_STEP: rd_step_q <= pwdata[7:0];
        `PTCH_OFS_RD_ITEM: rd_item_q <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // Validation of the request, registered before any store update
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      chk_err_q  <= `PTCH_ERR_NONE;
      eff_step_q <= 8'h00;
    end
    else if (state_q == ptch_pkg::PTCH_CHECK)
    begin
      eff_step_q <= item_q[15:8] != 8'h00 ? item_q[15:8] :
                    (loc_q[16] ? current_step_y : current_step_x);
      if (loc_q[7:0] != MY_BASE || loc_q[15:8] != MY_SLOT)
        chk_err_q <= `PTCH_ERR_SLOT;
      else if (loc_q[23:16] > 8'h01)
        chk_err_q <= `PTCH_ERR_AXIS;
      else
      begin
        chk_err_q <= `PTCH_ERR_NONE;
        unique case (cmd_q[1:0])
          `PTCH_CMD_COMMON:
          begin
            unique case (item_q[7:0])
              `PTCH_CI_ENC_MAX, `PTCH_CI_ENC_MIN: ;
              `PTCH_CI_OVR:
                if (!in_u(value_q, 32'h00000001))
                  chk_err_q <= `PTCH_ERR_VALUE;
              `PTCH_CI_ENC_FMT:
                if (!in_u(value_q, 32'h00000002))
                  chk_err_q <= `PTCH_ERR_VALUE;
              default: chk_err_q <= `PTCH_ERR_ITEM;
            endcase
          end
          `PTCH_CMD_STEP:
          begin
            if (item_q[15:8] > `PTCH_MAX_STEP)
              chk_err_q <= `PTCH_ERR_STEP;
            else if (item_q[7:0] == 8'h00 || item_q[7:0] > 8'h10)
              chk_err_q <= `PTCH_ERR_ITEM;
            else
            begin
              unique case (item_q[7:0])
                `PTCH_SI_GOAL, `PTCH_SI_AUX: ;
                `PTCH_SI_SPEED:
                  if (value_q == 32'h00000000 ||
                      !in_u(value_q, `PTCH_SPEED_MAX))
                    chk_err_q <= `PTCH_ERR_VALUE;
                8'h04, 8'h05, 8'h06:
                  if (!in_u(value_q, `PTCH_U16_MAX))
                    chk_err_q <= `PTCH_ERR_VALUE;
                8'h07, `PTCH_SI_CTRL, 8'h0A, 8'h0B, 8'h0F:
                  if (!in_u(value_q, 32'h00000001))
                    chk_err_q <= `PTCH_ERR_VALUE;
                `PTCH_SI_PATTERN, 8'h0E:
                  if (!in_u(value_q, 32'h00000002))
                    chk_err_q <= `PTCH_ERR_VALUE;
                8'h0C, 8'h0D:
                  if (!in_u(value_q, 32'h00000003))
                    chk_err_q <= `PTCH_ERR_VALUE;
                `PTCH_SI_REPSTEP:
                  if (value_q == 32'h00000000 ||
                      !in_u(value_q, {24'h000000, `PTCH_MAX_STEP}))
                    chk_err_q <= `PTCH_ERR_VALUE;
                default: ;
              endcase
            end
          end
          default: ; // Polarity takes any mask
        endcase
      end
      // Step zero with no step in use; a bad location keeps its own error
      if (cmd_q[1:0] == `PTCH_CMD_STEP && item_q[15:8] == 8'h00 &&
          (loc_q[16] ? current_step_y : current_step_x) == 8'h00 &&
          loc_q[7:0] == MY_BASE && loc_q[15:8] == MY_SLOT &&
          loc_q[23:16] <= 8'h01)
        chk_err_q <= `PTCH_ERR_STEP;
    end
  end

  // Sequencer: take, check, then write or reject
  always_ff @(posedge core_clk)
  begin
    if (srst)
      state_q <= ptch_pkg::PTCH_IDLE;
    else
    begin
      unique case (state_q)
        ptch_pkg::PTCH_IDLE:
          if (start_q)
            state_q <= ptch_pkg::PTCH_CHECK;
        ptch_pkg::PTCH_CHECK: state_q <= ptch_pkg::PTCH_WRITE;
        ptch_pkg::PTCH_WRITE: state_q <= ptch_pkg::PTCH_IDLE;
        default: state_q <= ptch_pkg::PTCH_IDLE;
      endcase
    end
  end

  assign fin_pulse = state_q == ptch_pkg::PTCH_WRITE;
  assign err_pulse = fin_pulse && chk_err_q != `PTCH_ERR_NONE;

  // Volatile parameter store; a flash save is another block's job
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      for (int a = 0; a < 2; a++)
      begin
        pol_q[a]     <= 6'h00;
        enc_max_q[a] <= 32'h00000000;
        enc_min_q[a] <= 32'h00000000;
        ovr_q[a]     <= 1'b0;
        enc_fmt_q[a] <= 2'h0;
      end
    end
    else if (fin_pulse && chk_err_q == `PTCH_ERR_NONE)
    begin
      unique case (cmd_q[1:0])
        `PTCH_CMD_POL:
          pol_q[loc_q[16]] <= value_q[`PTCH_POL_BITS-1:0];
        `PTCH_CMD_COMMON:
          unique case (item_q[7:0])
            `PTCH_CI_ENC_MAX: enc_max_q[loc_q[16]] <= value_q;
            `PTCH_CI_ENC_MIN: enc_min_q[loc_q[16]] <= value_q;
            `PTCH_CI_OVR:     ovr_q[loc_q[16]] <= value_q[0];
            `PTCH_CI_ENC_FMT: enc_fmt_q[loc_q[16]] <= value_q[1:0];
            default: ;
          endcase
        default: ;
      endcase
    end
  end

  // Step store has no reset; it powers up as undefined data
  always_ff @(posedge core_clk)
  begin
    if (fin_pulse && chk_err_q == `PTCH_ERR_NONE &&
        cmd_q[1:0] == `PTCH_CMD_STEP)
      step_mem[sidx(loc_q[16], eff_step_q, item_q[7:0])] <= value_q;
    rd_data_q <= step_mem[sidx(rd_step_q[0] ? 1'b1 : 1'b0, 8'h00, 8'h01)];
    if (rd_item_q >= 8'h01 && rd_item_q <= 8'h10 &&
        rd_step_q <= `PTCH_MAX_STEP)
      rd_data_q <= step_mem[sidx(loc_q[16], rd_step_q, rd_item_q)];
  end

  // Done sticks after the first finish; error latched with it
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      done_q <= 1'b0;
      err_q  <= `PTCH_ERR_NONE;
    end
    else if (fin_pulse)
    begin
      done_q <= 1'b1;
      err_q  <= chk_err_q;
    end
  end

  // Sticky events: bit0 finished, bit1 rejected; set beats clear
  always_ff @(posedge core_clk)
  begin
    if (srst)
      sts_q <= 2'h0;
    else
      sts_q <= (sts_q & ~((wr_en && paddr == `PTCH_OFS_IRQ_STS) ?
               pwdata[1:0] : 2'h0)) | {err_pulse, fin_pulse};
  end

  assign irq = |(sts_q & msk_q);

  // Polarity outputs: 1 means normally closed contact
  assign polarity_nc = {pol_q[1], pol_q[0]};

  // Read mux
  always_comb
  begin
    prdata = 32'h00000000;
    if (rd_en)
    begin
      unique case (paddr)
        `PTCH_OFS_CMD:     prdata = cmd_q;
        `PTCH_OFS_LOC:     prdata = loc_q;
        `PTCH_OFS_ITEM:    prdata = item_q;
        `PTCH_OFS_VALUE:   prdata = value_q;
        `PTCH_OFS_RESULT:
          prdata = {13'h0000, state_q != ptch_pkg::PTCH_IDLE, 1'b0,
                    done_q, err_q};
        `PTCH_OFS_IRQ_STS: prdata = {30'h00000000, sts_q};
        `PTCH_OFS_IRQ_MSK: prdata = {30'h00000000, msk_q};
        `PTCH_OFS_POL:
          prdata = {10'h000, pol_q[1], 10'h000, pol_q[0]};
        `PTCH_OFS_COMMON:
          prdata = {26'h0000000, enc_fmt_q[1], ovr_q[1],
                    enc_fmt_q[0], ovr_q[0]};
        `PTCH_OFS_CURSTEP: prdata = {16'h0000, current_step_y,
                                     current_step_x};
        `PTCH_OFS_RD_STEP: prdata = {24'h000000, rd_step_q};
        `PTCH_OFS_RD_ITEM: prdata = {24'h000000, rd_item_q};
        `PTCH_OFS_RD_DATA: prdata = rd_data_q;
        default: prdata = 32'h00000000;
      endcase
    end
  end

  // Encoder limits are stored but not readable over the bus
  logic unused_enc;
  assign unused_enc = ^{enc_max_q[0], enc_max_q[1], enc_min_q[0],
                        enc_min_q[1], cmd_q[31:2], loc_q[31:17],
                        item_q[31:16]};

  sequence req_seq;
    start_q ##1 state_q == ptch_pkg::PTCH_CHECK;
  endsequence

  start_to_done_a: assert property (@(posedge core_clk) disable iff (srst)
    req_seq |-> ##1 fin_pulse ##1 done_q)
    else $error("done not raised two cycles after check");
  axis_error_a: assert property (@(posedge core_clk) disable iff (srst)
    (state_q == ptch_pkg::PTCH_CHECK && loc_q[23:16] > 8'h01 &&
     loc_q[7:0] == MY_BASE && loc_q[15:8] == MY_SLOT)
    |-> ##2 err_q == `PTCH_ERR_AXIS)
    else $error("bad axis did not give error 6");
  done_sticky_a: assert property (@(posedge core_clk) disable iff (srst)
    done_q |=> done_q)
    else $error("done fell after being set");
  reject_keeps_a: assert property (@(posedge core_clk) disable iff (srst)
    err_pulse |=> $stable(pol_q[0]) && $stable(ovr_q[0]))
    else $error("store changed on rejected request");
  pol_write_a: assert property (@(posedge core_clk) disable iff (srst)
    (fin_pulse && chk_err_q == `PTCH_ERR_NONE &&
     cmd_q[1:0] == `PTCH_CMD_POL && !loc_q[16])
    |=> pol_q[0] == $past(value_q[5:0]))
    else $error("polarity mask not stored");
  speed_range_a: assert property (@(posedge core_clk) disable iff (srst)
    (state_q == ptch_pkg::PTCH_CHECK && cmd_q[1:0] == `PTCH_CMD_STEP &&
     item_q[7:0] == `PTCH_SI_SPEED && value_q == 32'h00000000)
    |=> chk_err_q != `PTCH_ERR_NONE)
    else $error("zero speed accepted");
  fmt_range_a: assert property (@(posedge core_clk) disable iff (srst)
    (state_q == ptch_pkg::PTCH_CHECK && cmd_q[1:0] == `PTCH_CMD_COMMON &&
     item_q[7:0] == `PTCH_CI_ENC_FMT && value_q > 32'h00000002)
    |=> chk_err_q != `PTCH_ERR_NONE)
    else $error("bad encoder format accepted");
  slot_check_a: assert property (@(posedge core_clk) disable iff (srst)
    (state_q == ptch_pkg::PTCH_CHECK && loc_q[15:8] != MY_SLOT)
    |=> chk_err_q == `PTCH_ERR_SLOT)
    else $error("wrong slot accepted");
  irq_level_a: assert property (@(posedge core_clk) disable iff (srst)
    (fin_pulse && msk_q[0]) |=> irq)
    else $error("finish event did not raise irq");

endmodule // ptch_handler
`default_nettype wire

// [ptch_plc_model.sv]
`timescale 1ns/1ns
`default_nettype none
`include "ptch_map.svh"
module ptch_plc_model (
  input  wire logic        core_clk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  output logic      [7:0]  current_step_x,
  output logic      [7:0]  current_step_y
);
  int n_tmo = 0;

  // Idle bus and known step numbers from time zero
  initial
  begin
    psel           = 1'b0;
    penable        = 1'b0;
    pwrite         = 1'b0;
    paddr          = 12'h000;
    pwdata         = 32'h00000000;
    current_step_x = 8'h00;
    current_step_y = 8'h03;
  end

  // One transfer; request held until pready is seen at a rising edge or 50 rising edges pass
  task automatic xfer(input logic wr, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    q = prdata;
    if (n >= 50)
      n_tmo++;
    psel    <= 1'b0;
    penable <= 1'b0;
    pwdata  <= ~d; // Released data must not look like a live value
  endtask

  // Step in use on axis 0, changed just after a rising edge
  task automatic set_cur_x(input logic [7:0] v);
    current_step_x <= v;
  endtask
endmodule // ptch_plc_model
`default_nettype wire

// [ptch_handler_bench.sv]
`timescale 1ns/1ns
`default_nettype none
`include "ptch_map.svh"
module ptch_handler_bench;
  logic        core_clk = 1'b0;
  logic        srst     = 1'b1;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  cur_x;
  logic [7:0]  cur_y;
  logic [11:0] polarity_nc;
  logic        irq;
  logic [31:0] q;
  int          n_fail = 0;
  int          checks = 0;

  // 25 MHz clock
  always #20 core_clk = ~core_clk;

  ptch_handler u_ptch_handler (.core_clk(core_clk), .srst(srst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .current_step_x(cur_x), .current_step_y(cur_y),
    .polarity_nc(polarity_nc), .irq(irq));

  ptch_plc_model u_ptch_plc_model (.core_clk(core_clk), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .current_step_x(cur_x),
    .current_step_y(cur_y));

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask

  task automatic give_verdict;
    if (n_fail == 0 && checks > 0 && u_ptch_plc_model.n_tmo == 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // One bus transfer; a bus that never answers ends the run
  task automatic xf(input logic w, input logic [11:0] a,
                    input logic [31:0] d);
    u_ptch_plc_model.xfer(w, a, d, q);
    if (u_ptch_plc_model.n_tmo != 0)
    begin
      n_fail++;
      give_verdict();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xf(1'b1, a, d);
  endtask

  task automatic rdchk(input string nm, input logic [11:0] a,
                       input logic [31:0] e);
    xf(1'b0, a, 32'h00000000);
    chk(nm, e, q);
  endtask

  // Load the request words, fire it, wait for busy to drop, check result
  task automatic teach(input logic [1:0] cmd, input logic [7:0] axis,
                       input logic [7:0] slot, input logic [15:0] item,
                       input logic [31:0] val, input logic [15:0] err);
    int n;
    wr(`PTCH_OFS_LOC, {8'h00, axis, slot, 8'h00});
    wr(`PTCH_OFS_ITEM, {16'h0000, item});
    wr(`PTCH_OFS_VALUE, val);
    wr(`PTCH_OFS_CMD, {30'h00000000, cmd});
    n = 0;
    do
    begin
      xf(1'b0, `PTCH_OFS_RESULT, 32'h00000000);
      n++;
    end
    while (q[18] !== 1'b0 && n < 20);
    if (n >= 20)
    begin
      n_fail++;
      give_verdict();
    end
    else
      chk("result", {15'h0000, 1'b1, err}, q);
  endtask

  // Step item teach on axis 0, then read the stored field back unless rs is zero
  task automatic step(input logic [7:0] s, input logic [7:0] it,
                      input logic [31:0] v, input logic [15:0] err,
                      input logic [7:0] rs, input logic [31:0] rb);
    teach(`PTCH_CMD_STEP, 8'h00, 8'h01, {s, it}, v, err);
    if (rs != 8'h00)
    begin
      wr(`PTCH_OFS_RD_STEP, {24'h000000, rs});
      wr(`PTCH_OFS_RD_ITEM, {24'h000000, it});
      rdchk("step_data", `PTCH_OFS_RD_DATA, rb);
    end
  endtask

  task automatic irq_chk(input logic e);
    @(negedge core_clk);
    chk("irq", {31'h00000000, e}, {31'h00000000, irq});
  endtask

  // Main sequence
  initial
  begin
    repeat (12) @(posedge core_clk);
    srst <= 1'b0;
    rdchk("result_rst", `PTCH_OFS_RESULT, 32'h00000000);
    chk("pol_rst", 32'h00000000, {20'h00000, polarity_nc});
    teach(`PTCH_CMD_POL, 8'h00, 8'h01, 16'h0, 32'h0000FFFF, 16'h0);
    chk("pol", 32'h0000003F, {20'h00000, polarity_nc});
    teach(`PTCH_CMD_POL, 8'h01, 8'h01, 16'h0, 32'h0000FFD5, 16'h0);
    chk("pol", 32'h0000057F, {20'h00000, polarity_nc});
    rdchk("pol_reg", `PTCH_OFS_POL, 32'h0015003F);
    teach(`PTCH_CMD_POL, 8'h02, 8'h01, 16'h0, 32'h0, `PTCH_ERR_AXIS);
    teach(`PTCH_CMD_POL, 8'h00, 8'h02, 16'h0, 32'h0, `PTCH_ERR_SLOT);
    chk("pol", 32'h0000057F, {20'h00000, polarity_nc});
    teach(`PTCH_CMD_COMMON, 8'h00, 8'h01, 16'h1, 32'hFFFFFFFB, 16'h0);
    teach(`PTCH_CMD_COMMON, 8'h00, 8'h01, 16'h2, 32'h80000000, 16'h0);
    teach(`PTCH_CMD_COMMON, 8'h00, 8'h01, 16'h3, 32'h0, 16'h0);
    teach(`PTCH_CMD_COMMON, 8'h00, 8'h01, 16'h3, 32'h1, 16'h0);
    teach(`PTCH_CMD_COMMON, 8'h00, 8'h01, 16'h4, 32'h0, 16'h0);
    teach(`PTCH_CMD_COMMON, 8'h00, 8'h01, 16'h4, 32'h1, 16'h0);
    teach(`PTCH_CMD_COMMON, 8'h00, 8'h01, 16'h4, 32'h2, 16'h0);
    teach(`PTCH_CMD_COMMON, 8'h00, 8'h01, 16'h4, 32'h3, 16'h000D);
    teach(`PTCH_CMD_COMMON, 8'h00, 8'h01, 16'h5, 32'h0, 16'h000C);
    rdchk("common", `PTCH_OFS_COMMON, 32'h00000005);
    step(8'h05, 8'h03, 32'h001E8480, 16'h0, 8'h05, 32'h001E8480);
    step(8'h05, 8'h03, 32'h0, 16'h000D, 8'h05, 32'h001E8480);
    step(8'h05, 8'h03, 32'h001E8481, 16'h000D, 8'h05, 32'h001E8480);
    step(8'h05, 8'h08, 32'h1, 16'h0, 8'h05, 32'h1);
    step(8'h05, 8'h08, 32'h0, 16'h0, 8'h05, 32'h0);
    step(8'h05, 8'h08, 32'h2, 16'h000D, 8'h05, 32'h0);
    step(8'h05, 8'h09, 32'h1, 16'h0, 8'h05, 32'h1);
    step(8'h05, 8'h09, 32'h2, 16'h0, 8'h05, 32'h2);
    step(8'h05, 8'h09, 32'h3, 16'h000D, 8'h05, 32'h2);
    step(8'h96, 8'h02, 32'h80000000, 16'h0, 8'h96, 32'h80000000);
    step(8'h97, 8'h01, 32'h0, 16'h000B, 8'h00, 32'h0);
    step(8'h05, 8'h11, 32'h0, 16'h000C, 8'h00, 32'h0);
    step(8'h00, 8'h01, 32'h0, 16'h000B, 8'h00, 32'h0);
    u_ptch_plc_model.set_cur_x(8'h07);
    step(8'h00, 8'h01, 32'hFFFFFFFF, 16'h0, 8'h07, 32'hFFFFFFFF);
    // Both events have fired by now; mask holds the line low
    rdchk("irq_sts", `PTCH_OFS_IRQ_STS, 32'h00000003);
    irq_chk(1'b0);
    wr(`PTCH_OFS_IRQ_MSK, 32'h00000001);
    irq_chk(1'b1);
    wr(`PTCH_OFS_IRQ_STS, 32'h00000001);
    irq_chk(1'b0);
    rdchk("irq_sts", `PTCH_OFS_IRQ_STS, 32'h00000002);
    wr(`PTCH_OFS_IRQ_MSK, 32'h00000003);
    irq_chk(1'b1);
    wr(`PTCH_OFS_IRQ_STS, 32'h00000003);
    irq_chk(1'b0);
    // A finish with the mask open must raise the line again
    teach(`PTCH_CMD_COMMON, 8'h01, 8'h01, 16'h3, 32'h1, 16'h0);
    irq_chk(1'b1);
    rdchk("irq_sts", `PTCH_OFS_IRQ_STS, 32'h00000001);
    rdchk("common", `PTCH_OFS_COMMON, 32'h0000000D);
    wr(`PTCH_OFS_IRQ_STS, 32'h00000001);
    irq_chk(1'b0);
    wr(12'h0FC, 32'hFFFFFFFF);
    rdchk("unmapped", 12'h0FC, 32'h00000000);
    rdchk("result", `PTCH_OFS_RESULT, 32'h00010000);
    give_verdict();
  end
endmodule // ptch_handler_bench
`default_nettype wire
